// File: test/serial_peer.sv
// remote async serial device: sends frames on the rx pin, captures frames from the tx pin
// assumes the caller passes wire-level bit vectors, start bit first
`timescale 1ns/10ps
module serial_peer #(parameter int BIT = 16) (
  input wire logic clock,
  input wire logic tx_line,
  output logic rx_line
);
  initial rx_line = 1'b1;
  // each bit held a full bit time, then the line returns to idle
  task send(input logic [11:0] f, input int n, input logic idle);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      rx_line <= f[i];
      repeat (BIT - 1) @(posedge clock);
    end
    @(posedge clock);
    rx_line <= idle;
  endtask : send
  // start edge found by polling, so sampling lands near mid-bit, not exactly there
  task grab(input int n, input logic idle, output logic [11:0] f, output bit ok);
    int t;
    f = 12'h000;
    ok = 1'b0;
    for (t = 0; t < 1000 && tx_line === idle; t++) @(posedge clock);
    if (tx_line !== idle) begin
      ok = 1'b1;
      repeat (BIT / 2) @(posedge clock);
      for (int i = 0; i < n; i++) begin
        f[i] = tx_line;
        repeat (BIT) @(posedge clock);
      end
    end
  endtask : grab
endmodule : serial_peer

// File: test/tb_top.sv
// self-checking bench for the async serial transceiver
// assumes base clock select 0 and divisor 8, so one bit is 16 clocks
`timescale 1ns/10ps
module tb_top;
  import uart_pkg::*;
  localparam int BIT = 16;
  localparam logic [4:0] CFG [4] = '{5'h12, 5'h0b, 5'h1c, 5'h16};
  localparam logic [1:0] INV [4] = '{2'b00, 2'b00, 2'b00, 2'b11};
  localparam logic [39:0] RA [8] = '{OFF_MAIN_CTL, OFF_BASE_CLK, OFF_BAUD_DIV, OFF_LINE_OPT, OFF_ERR_STAT,
    OFF_PORT3_MODE, OFF_PORT3_FUNC, 40'h0000000000};
  localparam logic [7:0] RE [8] = '{8'h10, 8'h00, 8'hff, 8'h14, 8'h00, 8'h00, 8'h00, 8'h00};
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic [DATA_W-1:0] reg_rdata;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rx_error_irq, rx_complete_irq, tx_buffer_free_irq;
  logic pin32_out, pin32_oe, pin33_out, pin33_oe, gpio_in_32, gpio_in_33, csi_data_in, rx_line;
  logic [4:0] cyc = 5'h00;
  int error_cnt = 0;
  int cmp_count = 0;
  int rxc_n = 0;
  int err_n = 0;
  int txf_n = 0;
  wire pin33_w = pin33_oe ? pin33_out : 1'b1;
  wire pin32_w = pin32_oe ? pin32_out : rx_line;
  always #5 clock = ~clock;
  // port-logic inputs keep moving so every pin mux path is exercised
  always @(posedge clock) begin
    cyc <= cyc + 5'h01;
    if (rx_complete_irq === 1'b1) rxc_n++;
    if (rx_error_irq === 1'b1) err_n++;
    if (tx_buffer_free_irq === 1'b1) txf_n++;
  end
  async_serial_unit dut_u (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_error_irq(rx_error_irq),
    .rx_complete_irq(rx_complete_irq), .tx_buffer_free_irq(tx_buffer_free_irq), .pin32_in(pin32_w),
    .pin32_out(pin32_out), .pin32_oe(pin32_oe), .pin33_in(pin33_w), .pin33_out(pin33_out), .pin33_oe(pin33_oe),
    .gpio_out_32(cyc[4]), .gpio_oe_32(cyc[2]), .gpio_out_33(cyc[0]), .gpio_oe_33(cyc[3]),
    .gpio_in_32(gpio_in_32), .gpio_in_33(gpio_in_33), .csi_data_out(cyc[1]), .csi_data_in(csi_data_in));
  serial_peer #(.BIT(BIT)) peer_u (.clock(clock), .tx_line(pin33_w), .rx_line(rx_line));
  task complete_run;
    $display("TB: mismatches=%0d compares=%0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task chk(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [39:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [39:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // wire-level frame: start, data in configured order, parity, stop bits
  function automatic logic [11:0] frame(input logic [7:0] d, input logic [4:0] c, input bit two, output int n);
    logic [11:0] f;
    int nb;
    logic p;
    f = 12'hfff;
    f[0] = 1'b0;
    nb = c[1] ? 8 : 7;
    for (int k = 0; k < nb; k++) f[k + 1] = c[4] ? d[k] : d[nb - 1 - k];
    p = ^(d & (c[1] ? 8'hff : 8'h7f));
    n = nb + 1;
    if (c[3:2] != PAR_NONE) begin
      f[n] = (c[3:2] == PAR_ZERO) ? 1'b0 : (c[3:2] == PAR_ODD) ? ~p : p;
      n++;
    end
    n += (two && c[0]) ? 2 : 1;
    return f;
  endfunction : frame
  task setup(input logic [4:0] c, input logic [1:0] inv);
    wr(OFF_MAIN_CTL, 8'h00);
    wr(OFF_LINE_OPT, 8'h14 | {6'h00, inv});
    // rx idle level set before enable, else an inverted line looks like a start bit
    peer_u.send(12'h000, 0, !inv[0]);
    wr(OFF_MAIN_CTL, {3'b100, c});
    wr(OFF_MAIN_CTL, {3'b111, c});
    repeat (30) @(posedge clock);
  endtask : setup
  initial begin
    logic [7:0] v, td, sd;
    logic [11:0] f, rf, g, m;
    int n, rn;
    bit ok;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd(RA[i], v);
      chk(v, RE[i]);
    end
    wr(OFF_PORT3_FUNC, 8'hff);
    rd(OFF_PORT3_FUNC, v);
    chk(v, 8'h2c);
    wr(OFF_PORT3_FUNC, 8'h00);
    chk({10'h000, pin32_out, pin33_oe}, {10'h000, cyc[4], cyc[3]});
    wr(OFF_PORT3_MODE, 8'h0c);
    repeat (8) @(posedge clock);
    // csi out loops back through the pin synchroniser, two cycles late
    chk({8'h00, gpio_in_32, csi_data_in, gpio_in_33, pin33_oe}, {8'h00, 1'b1, 1'b1, ~cyc[1], 1'b1});
    wr(OFF_PORT3_FUNC, 8'h0c);
    wr(OFF_BAUD_DIV, 8'h08);
    wr(OFF_BASE_CLK, 8'h00);
    for (int c = 0; c < 4; c++) begin
      setup(CFG[c], INV[c]);
      wr(OFF_MAIN_CTL, {3'b111, ~CFG[c]});
      rd(OFF_MAIN_CTL, v);
      chk(v, {3'b111, CFG[c]});
      td = 8'h96 + 8'(c * 37);
      sd = 8'hcb + 8'(c * 29);
      f = frame(td, CFG[c], 1'b1, n) ^ {12{INV[c][1]}};
      rf = frame(sd, CFG[c], 1'b0, rn) ^ {12{INV[c][0]}};
      m = 12'hfff >> (12 - n);
      wr(OFF_TX_BUF, td);
      fork
        peer_u.send(rf, rn, !INV[c][0]);
        peer_u.grab(n, !INV[c][1], g, ok);
      join
      if (!ok) begin
        error_cnt++;
        complete_run();
      end
      chk(g & m, f & m);
      rd(OFF_RX_BUF, v);
      chk(v, sd & (CFG[c][1] ? 8'hff : 8'h7f));
      chk(12'(rxc_n), 12'(c + 1));
      chk(12'(txf_n), 12'(c + 1));
    end
    setup(5'h0b, 2'b00);
    f = frame(8'h5a, 5'h0b, 1'b0, n);
    peer_u.send(f ^ 12'h200, n, 1'b1);
    rd(OFF_RX_BUF, v);
    peer_u.send(f ^ 12'h400, n, 1'b1);
    repeat (40) @(posedge clock);
    rd(OFF_RX_BUF, v);
    peer_u.send(f, n, 1'b1);
    peer_u.send(f ^ 12'h006, n, 1'b1);
    repeat (20) @(posedge clock);
    rd(OFF_RX_BUF, v);
    chk(v, 8'h5a);
    chk(12'(err_n), 12'h003);
    wr(OFF_ERR_STAT, 8'hff);
    rd(OFF_ERR_STAT, v);
    chk(v, 8'h07);
    wr(OFF_ERR_STAT, 8'h00);
    rd(OFF_ERR_STAT, v);
    chk(v, 8'h00);
    wr(OFF_MAIN_CTL, 8'h00);
    repeat (10) @(posedge clock);
    chk({11'h000, pin33_w}, 12'h001);
    complete_run();
  end
endmodule : tb_top

// File: test/uart_checker.sv
// port-level assertions for the async serial transceiver
// assumes one clock domain and a register map mirrored from the register port
`timescale 1ns/10ps
module uart_checker import uart_pkg::*; (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [uart_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [uart_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [uart_pkg::DATA_W-1:0] reg_rdata,
  input wire logic rx_error_irq,
  input wire logic rx_complete_irq,
  input wire logic tx_buffer_free_irq,
  input wire logic pin32_oe,
  input wire logic pin33_out,
  input wire logic gpio_oe_32,
  input wire logic gpio_out_33,
  input wire logic csi_data_out,
  input wire logic csi_data_in
);
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] func;
    logic [7:0] ctl;
    logic tdl;
  } mirror_t;
  mirror_t m_r;
  mirror_t m_nxt;
  logic uart_tx;
  logic csi_sel;
  assign uart_tx = m_r.mode[PIN_TX_BIT] & m_r.func[PIN_TX_BIT];
  assign csi_sel = m_r.mode[PIN_RX_BIT] & ~m_r.func[PIN_RX_BIT];
  // mirror keeps the refusal rules, so readback checks see the protected fields
  always_comb begin
    m_nxt = m_r;
    if (reg_wr && reg_addr == OFF_PORT3_MODE) m_nxt.mode = reg_wdata;
    if (reg_wr && reg_addr == OFF_PORT3_FUNC) m_nxt.func = reg_wdata & PORT3_FUNC_WMASK;
    if (reg_wr && reg_addr == OFF_MAIN_CTL) begin
      m_nxt.ctl[7:5] = reg_wdata[7:5];
      if (!(m_r.ctl[PWR_BIT] && (m_r.ctl[TXE_BIT] || m_r.ctl[RXE_BIT]))) m_nxt.ctl[4:0] = reg_wdata[4:0];
    end
    if (reg_wr && reg_addr == OFF_LINE_OPT && !(m_r.ctl[PWR_BIT] && m_r.ctl[TXE_BIT])) m_nxt.tdl = reg_wdata[TDL_BIT];
  end
  always_ff @(posedge clock) begin
    if (sys_rst) m_r <= {PORT3_RESET, PORT3_RESET, 8'h10, 1'b0};
    else m_r <= m_nxt;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_rd_ctl;
    reg_rd && reg_addr == OFF_MAIN_CTL;
  endsequence
  sequence s_start_lvl;
    pin33_out == m_r.tdl ##1 pin33_out == m_r.tdl;
  endsequence
  property p_ctl_readback; s_rd_ctl |=> reg_rdata == $past(m_r.ctl); endproperty
  a_ctl_readback: assert property (p_ctl_readback) else $error("main control readback wrong");
  property p_rdata_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");
  property p_rx_done; rx_complete_irq |-> $past(m_r.ctl[PWR_BIT] && m_r.ctl[RXE_BIT]) ##1 !rx_complete_irq; endproperty
  a_rx_done: assert property (p_rx_done) else $error("receive complete pulse wrong");
  property p_tx_free; tx_buffer_free_irq |-> $past(m_r.ctl[PWR_BIT] && m_r.ctl[TXE_BIT]) ##1 !tx_buffer_free_irq; endproperty
  a_tx_free: assert property (p_tx_free) else $error("buffer free pulse wrong");
  property p_err_pulse; rx_error_irq |-> $past(m_r.ctl[RXE_BIT]) ##1 !rx_error_irq; endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("error pulse wrong");
  property p_pin33_gpio; !m_r.mode[PIN_TX_BIT] |-> pin33_out == gpio_out_33; endproperty
  a_pin33_gpio: assert property (p_pin33_gpio) else $error("tx pin not on port logic");
  property p_pin33_csi; m_r.mode[PIN_TX_BIT] && !m_r.func[PIN_TX_BIT] |-> pin33_out == csi_data_out; endproperty
  a_pin33_csi: assert property (p_pin33_csi) else $error("tx pin not on clocked serial out");
  property p_pin32_oe; pin32_oe == (gpio_oe_32 && !m_r.mode[PIN_RX_BIT]); endproperty
  a_pin32_oe: assert property (p_pin32_oe) else $error("rx pin drive enable wrong");
  property p_csi_off; !csi_sel && !$past(csi_sel) && !$past(csi_sel, 2) |-> csi_data_in == 1'b0; endproperty
  a_csi_off: assert property (p_csi_off) else $error("clocked serial input not gated");
  property p_idle_off;
    uart_tx && !m_r.ctl[PWR_BIT] && !$past(m_r.ctl[PWR_BIT], 2) && $past(m_r.tdl, 2) == m_r.tdl
      |-> pin33_out == !m_r.tdl;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("tx pin not idle while off");
  property p_tx_start; tx_buffer_free_irq && uart_tx |-> s_start_lvl; endproperty
  a_tx_start: assert property (p_tx_start) else $error("no start bit at buffer transfer");
endmodule : uart_checker

bind async_serial_unit uart_checker chk_u (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_error_irq(rx_error_irq),
  .rx_complete_irq(rx_complete_irq), .tx_buffer_free_irq(tx_buffer_free_irq), .pin32_oe(pin32_oe),
  .pin33_out(pin33_out), .gpio_oe_32(gpio_oe_32), .gpio_out_33(gpio_out_33), .csi_data_out(csi_data_out),
  .csi_data_in(csi_data_in));

// File: verilog/async_serial_unit.sv
// async serial transceiver with baud generator, buffers and shared pin mux
// assumes a synchronous master on the register port and raw pins on port 3
//
// Our own choice: strobed register access.
`timescale 1ns/10ps

// Overview of operation
// - dedicated baud generator: base clock prescaler and 8-bit divisor
// - receive and transmit run independently, each with own buffer
// - 7 or 8 data bits, msb-first or lsb-first
// - parity odd, even, fixed zero or none
// - transmitter sends one or two stop bits
// - receive input and transmit output can each be inverted
// - error interrupt is or of parity, framing and overrun
// - receive-complete pulse when frame moves into receive buffer
// - buffer-free pulse when character moves into transmit shifter
// - each receive error sets its own sticky status flag
// - receiver assembles bits, copies character after stop bit
// - 7-bit characters leave buffer bit 7 at zero
// - shift registers are not visible to software
// - writing transmit buffer starts a transmission
// - main control register is 8 bits, read/write, resets to 10h
// - separate base clock select and baud divisor registers
// - tx pin: port, clocked serial out, or uart tx by mode/function
// - rx pin: port, clocked serial in, or uart rx by mode/function
// - power bit low resets unit, tx pin idles at inactive level
// - units start two base clock cycles after enable
// - parity code 00 none, 01 zero, 10 odd, 11 even
// - length bit 0 gives 7 bits; only first stop bit checked
module async_serial_unit import uart_pkg::*; (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [uart_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [uart_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [uart_pkg::DATA_W-1:0] reg_rdata,
  output logic rx_error_irq,
  output logic rx_complete_irq,
  output logic tx_buffer_free_irq,
  input wire logic pin32_in,
  output logic pin32_out,
  output logic pin32_oe,
  input wire logic pin33_in,
  output logic pin33_out,
  output logic pin33_oe,
  input wire logic gpio_out_32,
  input wire logic gpio_oe_32,
  input wire logic gpio_out_33,
  input wire logic gpio_oe_33,
  output logic gpio_in_32,
  output logic gpio_in_33,
  input wire logic csi_data_out,
  output logic csi_data_in
);
  import uart_pkg::*;

  typedef struct packed {
    logic [7:0] main_ctl;
    logic [7:0] base_clk;
    logic [7:0] baud_div;
    logic [1:0] line_lvl;
    logic [7:0] port3_mode;
    logic [7:0] port3_func;
    logic tsf;
    logic pe;
    logic fe;
    logic ove;
    logic [7:0] rx_buf;
    logic rx_full;
    logic [7:0] tx_buf;
    logic tx_full;
    logic [7:0] rdata;
    logic [7:0] pre_cnt;
    logic [1:0] tx_en_sh;
    logic [1:0] rx_en_sh;
    frame_state_t tx_st;
    logic [8:0] tx_cnt;
    logic [2:0] tx_idx;
    logic [7:0] tx_sh;
    logic tx_line;
    frame_state_t rx_st;
    logic [8:0] rx_cnt;
    logic [2:0] rx_idx;
    logic [7:0] rx_sh;
    logic rx_par;
    logic p32_meta;
    logic p32_sync;
    logic p33_meta;
    logic p33_sync;
    logic irq_err;
    logic irq_rx;
    logic irq_tx;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  function automatic state_t reset_state();
    state_t r;
    r = '0;
    r.main_ctl = MAIN_CTL_RESET;
    r.base_clk = BASE_CLK_RESET;
    r.baud_div = BAUD_DIV_RESET;
    r.port3_mode = PORT3_RESET;
    r.port3_func = PORT3_RESET;
    r.tx_st = FS_IDLE;
    r.rx_st = FS_IDLE;
    r.tx_line = 1'b1;
    r.p32_meta = 1'b1;
    r.p32_sync = 1'b1;
    r.p33_meta = 1'b1;
    r.p33_sync = 1'b1;
    return r;
  endfunction : reset_state

  // position in the character of the idx-th bit on the line
  function automatic logic [2:0] bit_pos(input logic [2:0] idx, input logic len8, input logic lsb_first);
    logic [2:0] last;
    last = len8 ? LAST_IDX_8 : LAST_IDX_7;
    bit_pos = lsb_first ? idx : 3'(last - idx);
  endfunction : bit_pos

  function automatic logic [2:0] last_idx(input logic len8);
    last_idx = len8 ? LAST_IDX_8 : LAST_IDX_7;
  endfunction : last_idx

  function automatic logic par_bit(input logic [7:0] d, input logic len8, input logic [1:0] ps);
    logic ones;
    ones = len8 ? ^d : ^d[6:0];
    case (ps)
      PAR_ODD: par_bit = ~ones;
      PAR_EVEN: par_bit = ones;
      default: par_bit = 1'b0;
    endcase
  endfunction : par_bit

  logic pwr;
  logic tx_on;
  logic rx_on;
  logic tx_act;
  logic rx_act;
  logic len8;
  logic lsb_first;
  logic [1:0] ps;
  logic tdl;
  logic rdl;
  logic [7:0] clk_mask;
  logic base_tick;
  logic [7:0] div;
  logic [8:0] bit_len;
  logic [8:0] half_len;
  logic uart_rx_sel;
  logic uart_tx_sel;
  logic serial_rx_pin;
  logic serial_tx_pin;
  logic ctl_locked;
  logic rx_read;
  logic perr;
  logic ferr;
  logic oerr;

  always_comb begin
    pwr = s_r.main_ctl[PWR_BIT];
    tx_on = pwr & s_r.main_ctl[TXE_BIT];
    rx_on = pwr & s_r.main_ctl[RXE_BIT];
    tx_act = tx_on & (s_r.tx_en_sh == ENABLE_DONE);
    rx_act = rx_on & (s_r.rx_en_sh == ENABLE_DONE);
    len8 = s_r.main_ctl[CL_BIT];
    lsb_first = s_r.main_ctl[DIR_BIT];
    ps = s_r.main_ctl[PS_HI_BIT:PS_LO_BIT];
    tdl = s_r.line_lvl[TDL_BIT];
    rdl = s_r.line_lvl[RDL_BIT];
    clk_mask = 8'((9'h001 << s_r.base_clk[CLK_SEL_W-1:0]) - 9'h001);
    base_tick = pwr & ((s_r.pre_cnt & clk_mask) == clk_mask);
    div = (s_r.baud_div < MIN_DIVISOR) ? MIN_DIVISOR : s_r.baud_div;
    bit_len = {div, 1'b0};
    half_len = {1'b0, div};
    uart_rx_sel = s_r.port3_mode[PIN_RX_BIT] & s_r.port3_func[PIN_RX_BIT];
    uart_tx_sel = s_r.port3_mode[PIN_TX_BIT] & s_r.port3_func[PIN_TX_BIT];
    // unselected pin reads as idle after inversion
    serial_rx_pin = (uart_rx_sel ? s_r.p32_sync : ~rdl) ^ rdl;
    serial_tx_pin = (pwr ? s_r.tx_line : 1'b1) ^ tdl;
    ctl_locked = pwr & (s_r.main_ctl[TXE_BIT] | s_r.main_ctl[RXE_BIT]);
    rx_read = reg_rd & (reg_addr == OFF_RX_BUF);
    perr = 1'b0;
    ferr = 1'b0;
    oerr = 1'b0;

    s_nxt = s_r;
    s_nxt.irq_err = 1'b0;
    s_nxt.irq_rx = 1'b0;
    s_nxt.irq_tx = 1'b0;
    s_nxt.p32_meta = pin32_in;
    s_nxt.p32_sync = s_r.p32_meta;
    s_nxt.p33_meta = pin33_in;
    s_nxt.p33_sync = s_r.p33_meta;
    s_nxt.pre_cnt = pwr ? 8'(s_r.pre_cnt + 8'h01) : 8'h00;

    // register reads, data valid in the following cycle only
    s_nxt.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        OFF_PORT3_MODE: s_nxt.rdata = s_r.port3_mode;
        OFF_PORT3_FUNC: s_nxt.rdata = s_r.port3_func;
        OFF_MAIN_CTL: s_nxt.rdata = s_r.main_ctl;
        OFF_BASE_CLK: s_nxt.rdata = s_r.base_clk;
        OFF_BAUD_DIV: s_nxt.rdata = s_r.baud_div;
        OFF_LINE_OPT: s_nxt.rdata = LINE_OPT_FIXED | {6'h00, s_r.line_lvl};
        OFF_ERR_STAT: s_nxt.rdata = {s_r.tsf, 4'h0, s_r.pe, s_r.fe, s_r.ove};
        OFF_RX_BUF: s_nxt.rdata = s_r.rx_buf;
        default: s_nxt.rdata = 8'h00;
      endcase
    end
    if (rx_read) begin
      s_nxt.rx_full = 1'b0;
    end

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        OFF_PORT3_MODE: s_nxt.port3_mode = reg_wdata;
        OFF_PORT3_FUNC: s_nxt.port3_func = reg_wdata & PORT3_FUNC_WMASK;
        OFF_MAIN_CTL: begin
          // format bits frozen while a running unit could see them change
          if (ctl_locked) begin
            s_nxt.main_ctl = {reg_wdata[7:CFG_MSB+1], s_r.main_ctl[CFG_MSB:0]};
          end else begin
            s_nxt.main_ctl = reg_wdata;
          end
        end
        OFF_BASE_CLK: s_nxt.base_clk = reg_wdata;
        OFF_BAUD_DIV: s_nxt.baud_div = reg_wdata;
        OFF_LINE_OPT: begin
          if (!tx_on) begin
            s_nxt.line_lvl[TDL_BIT] = reg_wdata[TDL_BIT];
          end
          if (!rx_on) begin
            s_nxt.line_lvl[RDL_BIT] = reg_wdata[RDL_BIT];
          end
        end
        OFF_ERR_STAT: begin
          // flags clear by writing zero, a one leaves them
          s_nxt.pe = s_r.pe & reg_wdata[PE_BIT];
          s_nxt.fe = s_r.fe & reg_wdata[FE_BIT];
          s_nxt.ove = s_r.ove & reg_wdata[OVE_BIT];
        end
        default: ;
      endcase
    end

    // enable delay counts base clock cycles
    if (!tx_on) begin
      s_nxt.tx_en_sh = 2'b00;
    end else if (base_tick) begin
      s_nxt.tx_en_sh = {s_r.tx_en_sh[0], 1'b1};
    end
    if (!rx_on) begin
      s_nxt.rx_en_sh = 2'b00;
    end else if (base_tick) begin
      s_nxt.rx_en_sh = {s_r.rx_en_sh[0], 1'b1};
    end

    // transmitter
    if (!tx_act) begin
      s_nxt.tx_st = FS_IDLE;
      s_nxt.tx_line = 1'b1;
      s_nxt.tx_cnt = 9'h000;
      s_nxt.tx_full = 1'b0;
      s_nxt.tsf = 1'b0;
    end else if (base_tick) begin
      if (s_r.tx_st == FS_IDLE) begin
        if (s_r.tx_full) begin
          s_nxt.tx_sh = s_r.tx_buf;
          s_nxt.tx_full = 1'b0;
          s_nxt.irq_tx = 1'b1;
          s_nxt.tx_st = FS_START;
          s_nxt.tx_line = 1'b0;
          s_nxt.tx_cnt = 9'h000;
        end
      end else if (s_r.tx_cnt != 9'(bit_len - 9'h001)) begin
        s_nxt.tx_cnt = 9'(s_r.tx_cnt + 9'h001);
      end else begin
        s_nxt.tx_cnt = 9'h000;
        case (s_r.tx_st)
          FS_START: begin
            s_nxt.tx_st = FS_DATA;
            s_nxt.tx_idx = 3'h0;
            s_nxt.tx_line = s_r.tx_sh[bit_pos(3'h0, len8, lsb_first)];
          end
          FS_DATA: begin
            if (s_r.tx_idx == last_idx(len8)) begin
              s_nxt.tx_idx = 3'h0;
              if (ps == PAR_NONE) begin
                s_nxt.tx_st = FS_STOP;
                s_nxt.tx_line = 1'b1;
              end else begin
                s_nxt.tx_st = FS_PARITY;
                s_nxt.tx_line = par_bit(s_r.tx_sh, len8, ps);
              end
            end else begin
              s_nxt.tx_idx = 3'(s_r.tx_idx + 3'h1);
              s_nxt.tx_line = s_r.tx_sh[bit_pos(3'(s_r.tx_idx + 3'h1), len8, lsb_first)];
            end
          end
          FS_PARITY: begin
            s_nxt.tx_st = FS_STOP;
            s_nxt.tx_line = 1'b1;
          end
          FS_STOP: begin
            if (s_r.main_ctl[SL_BIT] && s_r.tx_idx == 3'h0) begin
              s_nxt.tx_idx = 3'h1;
            end else begin
              s_nxt.tx_st = FS_IDLE;
              if (!s_r.tx_full) begin
                s_nxt.tsf = 1'b0;
              end
            end
          end
          default: s_nxt.tx_st = FS_IDLE;
        endcase
      end
    end
    // a write in the same cycle as a hand-off refills the buffer
    if (reg_wr && reg_addr == OFF_TX_BUF && tx_act) begin
      s_nxt.tx_buf = reg_wdata;
      s_nxt.tx_full = 1'b1;
      s_nxt.tsf = 1'b1;
    end

    // receiver
    if (!rx_on) begin
      s_nxt.pe = 1'b0;
      s_nxt.fe = 1'b0;
      s_nxt.ove = 1'b0;
      s_nxt.rx_full = 1'b0;
    end
    if (!rx_act) begin
      // start bits before the unit is live are ignored
      s_nxt.rx_st = FS_IDLE;
      s_nxt.rx_cnt = 9'h000;
    end else if (base_tick) begin
      case (s_r.rx_st)
        FS_IDLE: begin
          if (!serial_rx_pin) begin
            s_nxt.rx_st = FS_START;
            s_nxt.rx_cnt = 9'h000;
          end
        end
        FS_START: begin
          if (s_r.rx_cnt == 9'(half_len - 9'h001)) begin
            s_nxt.rx_cnt = 9'h000;
            s_nxt.rx_idx = 3'h0;
            s_nxt.rx_sh = 8'h00;
            s_nxt.rx_st = serial_rx_pin ? FS_IDLE : FS_DATA;
          end else begin
            s_nxt.rx_cnt = 9'(s_r.rx_cnt + 9'h001);
          end
        end
        FS_DATA, FS_PARITY, FS_STOP: begin
          if (s_r.rx_cnt != 9'(bit_len - 9'h001)) begin
            s_nxt.rx_cnt = 9'(s_r.rx_cnt + 9'h001);
          end else begin
            s_nxt.rx_cnt = 9'h000;
            if (s_r.rx_st == FS_DATA) begin
              s_nxt.rx_sh[bit_pos(s_r.rx_idx, len8, lsb_first)] = serial_rx_pin;
              if (s_r.rx_idx == last_idx(len8)) begin
                s_nxt.rx_st = (ps == PAR_NONE) ? FS_STOP : FS_PARITY;
              end else begin
                s_nxt.rx_idx = 3'(s_r.rx_idx + 3'h1);
              end
            end else if (s_r.rx_st == FS_PARITY) begin
              s_nxt.rx_par = serial_rx_pin;
              s_nxt.rx_st = FS_STOP;
            end else begin
              // only the first stop bit is looked at
              perr = ps[1] & (s_r.rx_par != par_bit(s_r.rx_sh, len8, ps));
              ferr = ~serial_rx_pin;
              oerr = s_r.rx_full & ~rx_read;
              s_nxt.pe = s_nxt.pe | perr;
              s_nxt.fe = s_nxt.fe | ferr;
              s_nxt.ove = s_nxt.ove | oerr;
              s_nxt.irq_err = perr | ferr | oerr;
              // on overrun the unread character is kept
              if (!oerr) begin
                s_nxt.rx_buf = s_r.rx_sh;
                s_nxt.rx_full = 1'b1;
                s_nxt.irq_rx = 1'b1;
              end
              s_nxt.rx_st = FS_IDLE;
            end
          end
        end
        default: s_nxt.rx_st = FS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_r <= reset_state();
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign rx_error_irq = s_r.irq_err;
  assign rx_complete_irq = s_r.irq_rx;
  assign tx_buffer_free_irq = s_r.irq_tx;

  // shared pins
  assign pin33_out = !s_r.port3_mode[PIN_TX_BIT] ? gpio_out_33 :
                     (uart_tx_sel ? serial_tx_pin : csi_data_out);
  assign pin33_oe = s_r.port3_mode[PIN_TX_BIT] | gpio_oe_33;
  assign pin32_out = gpio_out_32;
  assign pin32_oe = ~s_r.port3_mode[PIN_RX_BIT] & gpio_oe_32;
  assign csi_data_in = (s_r.port3_mode[PIN_RX_BIT] & ~s_r.port3_func[PIN_RX_BIT]) ? s_r.p32_sync : 1'b0;
  assign gpio_in_32 = s_r.p32_sync;
  assign gpio_in_33 = s_r.p33_sync;

endmodule : async_serial_unit

// File: verilog/uart_pkg.sv
// constants, register map and frame states of the async serial transceiver
// assumes one 100 MHz clock and a plain byte-wide register port
package uart_pkg;

  localparam int ADDR_W = 40;
  localparam int DATA_W = 8;

  // register addresses
  localparam logic [ADDR_W-1:0] OFF_PORT3_MODE = 40'h00fffff446;
  localparam logic [ADDR_W-1:0] OFF_PORT3_FUNC = 40'h00fffff466;
  localparam logic [ADDR_W-1:0] OFF_MAIN_CTL = 40'hfffffffa00;
  localparam logic [ADDR_W-1:0] OFF_BASE_CLK = 40'hfffffffa01;
  localparam logic [ADDR_W-1:0] OFF_BAUD_DIV = 40'hfffffffa02;
  localparam logic [ADDR_W-1:0] OFF_LINE_OPT = 40'hfffffffa03;
  localparam logic [ADDR_W-1:0] OFF_ERR_STAT = 40'hfffffffa04;
  localparam logic [ADDR_W-1:0] OFF_RX_BUF = 40'hfffffffa06;
  localparam logic [ADDR_W-1:0] OFF_TX_BUF = 40'hfffffffa07;

  // reset values
  localparam logic [7:0] MAIN_CTL_RESET = 8'h10;
  localparam logic [7:0] BASE_CLK_RESET = 8'h00;
  localparam logic [7:0] BAUD_DIV_RESET = 8'hff;
  localparam logic [7:0] PORT3_RESET = 8'h00;
  localparam logic [7:0] LINE_OPT_FIXED = 8'h14;

  // main control fields
  localparam int PWR_BIT = 7;
  localparam int TXE_BIT = 6;
  localparam int RXE_BIT = 5;
  localparam int DIR_BIT = 4;
  localparam int PS_HI_BIT = 3;
  localparam int PS_LO_BIT = 2;
  localparam int CL_BIT = 1;
  localparam int SL_BIT = 0;
  localparam int CFG_MSB = 4;

  // line option fields
  localparam int TDL_BIT = 1;
  localparam int RDL_BIT = 0;

  // status fields
  localparam int TSF_BIT = 7;
  localparam int PE_BIT = 2;
  localparam int FE_BIT = 1;
  localparam int OVE_BIT = 0;

  // shared port pins
  localparam int PIN_TX_BIT = 3;
  localparam int PIN_RX_BIT = 2;
  localparam logic [7:0] PORT3_FUNC_WMASK = 8'h2c;

  // parity field codes
  localparam logic [1:0] PAR_NONE = 2'b00;
  localparam logic [1:0] PAR_ZERO = 2'b01;
  localparam logic [1:0] PAR_ODD = 2'b10;
  localparam logic [1:0] PAR_EVEN = 2'b11;

  // timing
  localparam int CLK_SEL_W = 3;
  localparam logic [7:0] MIN_DIVISOR = 8'h02;
  localparam logic [2:0] LAST_IDX_8 = 3'h7;
  localparam logic [2:0] LAST_IDX_7 = 3'h6;
  localparam logic [1:0] ENABLE_DONE = 2'b11;

  typedef enum logic [4:0] {
    FS_IDLE = 5'b00001,
    FS_START = 5'b00010,
    FS_DATA = 5'b00100,
    FS_PARITY = 5'b01000,
    FS_STOP = 5'b10000
  } frame_state_t;

endpackage : uart_pkg
